// File: logic/scd_pkg.sv
// Constants shared by the serial column driver modules
package scd_pkg;
    localparam int CHANNELS = 80;
    localparam int GROUP_BITS = 4;
    localparam int GROUPS = 20;
    localparam int CNT_W = 7;
    localparam int SEL_W = 5;
    localparam int GRP_LSB = 2;
    localparam int GRP_DW = SEL_W + GROUP_BITS;
    localparam int LVL_W = 2;
    localparam int FIFO_DEPTH = 2;
    localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
    localparam logic [CNT_W-1:0] CNT_LAST = 7'h4f;
    localparam logic [GRP_LSB-1:0] NIB_LAST = 2'h3;
    localparam logic [SEL_W-1:0] GRP_MAX = 5'h13;
    // Drive level codes: 0..3 pick V1..V4
    localparam logic [LVL_W-1:0] LVL_SEL_POS = 2'h0;
    localparam logic [LVL_W-1:0] LVL_SEL_NEG = 2'h1;
    localparam logic [LVL_W-1:0] LVL_NON_POS = 2'h2;
    localparam logic [LVL_W-1:0] LVL_NON_NEG = 2'h3;
endpackage : scd_pkg

// File: logic/scd_grp_if.sv
// Valid/ready carrier for converted 4-bit groups
`timescale 1ns/100ps
interface scd_grp_if #(parameter int DW = 9);
    logic valid;
    logic ready;
    logic [DW-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : scd_grp_if

// File: logic/scd_pair_fifo.sv
// Small flip-flop FIFO between group assembly and the first latch
`timescale 1ns/100ps
module scd_pair_fifo #(
    parameter int DW = 9,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Fill and drain sides
    scd_grp_if.snk wr,
    scd_grp_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

    logic [DW-1:0] mem_r [DEPTH];
    logic [DW-1:0] mem_nxt [DEPTH];
    logic [AW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign wr.ready = (cnt_r != FULL);
    assign rd.valid = (cnt_r != '0);
    assign rd.data = mem_r[rptr_r];

    always_comb
    begin
        push = wr.valid & wr.ready;
        pop = rd.valid & rd.ready;
        mem_nxt = mem_r;
        wptr_nxt = wptr_r;
        rptr_nxt = rptr_r;
        cnt_nxt = cnt_r;
        if (push)
        begin
            mem_nxt[wptr_r] = wr.data;
            wptr_nxt = (wptr_r == PTR_LAST) ? '0 : wptr_r + 1'b1;
        end
        if (pop)
            rptr_nxt = (rptr_r == PTR_LAST) ? '0 : rptr_r + 1'b1;
        if (push && !pop)
            cnt_nxt = cnt_r + 1'b1;
        else if (pop && !push)
            cnt_nxt = cnt_r - 1'b1;
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem_r[i] <= '0;
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            mem_r <= mem_nxt;
            wptr_r <= wptr_nxt;
            rptr_r <= rptr_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule : scd_pair_fifo

// File: logic/scd_top.sv
// Serial to parallel 80-channel column driver core
`timescale 1ns/100ps
// Contract
// - Each channel drives one of four levels picked by its second-latch bit and the alternation signal.
// - Each falling line latch clock edge copies all 80 first-latch bits into the second latch.
// - Incoming serial bits are assembled into 4-bit groups before reaching the first latch.
// - Direction low takes data on the left port and drives the right port; the controller leaves right undriven.
// - Direction high takes data on the right port; the controller leaves the left port alone.
// - The first latch captures each 4-bit group on its own strobe, twenty strobes covering the line.
// - The first latch fills positions 1 to 80 upward with direction low and 80 to 1 with it high.
// - A selector decodes the transfer counter into at most one group strobe at a time.
// - While the device is inactive and the FIFO is empty no strobes occur, so the first latch holds its contents.
// - Panel duty follows only from the controller's shift and latch clock rates, static or dynamic.
// - After 80 converted bits the carry output goes low and the enable flag clears, stopping conversion.
// - The transfer counter is 7 bits wide and its upper 5 bits feed the group selector.
// - The carry output returns high at the rising line latch clock edge for the next cascaded device.
module scd_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Controller clocks and controls
    input wire logic line_latch_clock,
    input wire logic serial_shift_clock,
    input wire logic shift_direction_select,
    input wire logic alternation,
    input wire logic chain_enable_n,
    // Serial ports
    input wire logic left_serial_port_i,
    output logic left_serial_port_o,
    output logic left_serial_port_oe_n,
    input wire logic right_serial_port_i,
    output logic right_serial_port_o,
    output logic right_serial_port_oe_n,
    // Cascade and drive outputs
    output logic chain_carry_n,
    output logic [scd_pkg::CHANNELS*scd_pkg::LVL_W-1:0] drive_level
);
    localparam int CH = scd_pkg::CHANNELS;
    localparam int GB = scd_pkg::GROUP_BITS;
    localparam int NG = scd_pkg::GROUPS;
    localparam int LW = scd_pkg::LVL_W;
    localparam int CW = scd_pkg::CNT_W;
    localparam int GL = scd_pkg::GRP_LSB;

    function automatic logic [NG-1:0] grp_strobe(input logic [scd_pkg::SEL_W-1:0] idx);
        grp_strobe = NG'(1) << idx;
    endfunction : grp_strobe

    function automatic logic [GB-1:0] nib_rev(input logic [GB-1:0] v);
        for (int i = 0; i < GB; i++)
            nib_rev[i] = v[GB-1-i];
    endfunction : nib_rev

    // Two-stage synchronisers plus one history stage for edges
    localparam int NS = 7;
    logic [NS-1:0] s1_r, s2_r, async_in;
    logic l1_d_r, sh_d_r;
    assign async_in = {line_latch_clock, serial_shift_clock, shift_direction_select, alternation,
                       chain_enable_n, left_serial_port_i, right_serial_port_i};
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_r <= '0;
            s2_r <= '0;
            l1_d_r <= 1'b0;
            sh_d_r <= 1'b0;
        end
        else
        begin
            s1_r <= async_in;
            s2_r <= s1_r;
            l1_d_r <= s2_r[NS-1];
            sh_d_r <= s2_r[NS-2];
        end
    end

    logic l1_s, sh_s, dir_s, alt_s, en_n_s, left_s, right_s;
    assign {l1_s, sh_s, dir_s, alt_s, en_n_s, left_s, right_s} = s2_r;
    logic l1_fall, l1_rise, sh_fall, data_in;
    assign l1_fall = l1_d_r & ~l1_s;
    assign l1_rise = ~l1_d_r & l1_s;
    assign sh_fall = sh_d_r & ~sh_s;
    assign data_in = dir_s ? right_s : left_s;

    scd_grp_if #(.DW(scd_pkg::GRP_DW)) push_if ();
    scd_grp_if #(.DW(scd_pkg::GRP_DW)) pop_if ();

    scd_pair_fifo #(.DW(scd_pkg::GRP_DW), .DEPTH(scd_pkg::FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .rstn(rstn),
        .wr(push_if.snk),
        .rd(pop_if.src)
    );

    // Conversion control
    logic en_flag_r, en_flag_nxt, carry_n_r, carry_n_nxt, pend_r, pend_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [GB-1:0] nib_r, nib_nxt;
    logic [scd_pkg::GRP_DW-1:0] grp_r, grp_nxt;
    logic dout_r, dout_nxt;
    logic active, take, done_evt;
    logic [scd_pkg::SEL_W-1:0] grp_idx;

    assign active = en_flag_r & ~en_n_s;
    assign take = sh_fall & active & ~(pend_r & ~push_if.ready);
    assign done_evt = take & (cnt_r == scd_pkg::CNT_LAST);
    assign grp_idx = cnt_r[CW-1:GL];
    assign push_if.valid = pend_r;
    assign push_if.data = grp_r;

    always_comb
    begin
        nib_nxt = nib_r;
        cnt_nxt = cnt_r;
        grp_nxt = grp_r;
        dout_nxt = dout_r;
        pend_nxt = pend_r & ~push_if.ready;
        if (l1_s)
            en_flag_nxt = 1'b1;
        else if (done_evt)
            en_flag_nxt = 1'b0;
        else
            en_flag_nxt = en_flag_r;
        if (l1_rise)
            carry_n_nxt = 1'b1;
        else if (done_evt)
            carry_n_nxt = 1'b0;
        else
            carry_n_nxt = carry_n_r;
        if (l1_rise)
            cnt_nxt = scd_pkg::CNT_ZERO;
        else if (take)
        begin
            nib_nxt[cnt_r[GL-1:0]] = data_in;
            dout_nxt = data_in;
            cnt_nxt = done_evt ? scd_pkg::CNT_ZERO : cnt_r + scd_pkg::CNT_ONE;
            if (cnt_r[GL-1:0] == scd_pkg::NIB_LAST)
            begin
                // Whole group ready; mirror placement when shifting from the right
                pend_nxt = 1'b1;
                if (dir_s)
                    grp_nxt = {scd_pkg::GRP_MAX - grp_idx, nib_rev(nib_nxt)};
                else
                    grp_nxt = {grp_idx, nib_nxt};
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            en_flag_r <= 1'b0;
            carry_n_r <= 1'b1;
            pend_r <= 1'b0;
            cnt_r <= '0;
            nib_r <= '0;
            grp_r <= '0;
            dout_r <= 1'b0;
        end
        else
        begin
            en_flag_r <= en_flag_nxt;
            carry_n_r <= carry_n_nxt;
            pend_r <= pend_nxt;
            cnt_r <= cnt_nxt;
            nib_r <= nib_nxt;
            grp_r <= grp_nxt;
            dout_r <= dout_nxt;
        end
    end

    // Selector, latches and level drive
    logic [NG-1:0] strobe;
    logic [CH-1:0] latch1_r, latch1_nxt, latch2_r, latch2_nxt;
    logic [CH*LW-1:0] level_r, level_nxt;
    logic lo_oe_n_r, ro_oe_n_r, lo_r, ro_r;

    // Latch copy takes the cycle; the FIFO holds any group meanwhile
    assign pop_if.ready = ~l1_fall;
    assign strobe = (pop_if.valid & pop_if.ready) ? grp_strobe(pop_if.data[GB +: scd_pkg::SEL_W]) : '0;

    always_comb
    begin
        latch1_nxt = latch1_r;
        for (int g = 0; g < NG; g++)
            if (strobe[g])
                latch1_nxt[g*GB +: GB] = pop_if.data[GB-1:0];
        latch2_nxt = l1_fall ? latch1_r : latch2_r;
        for (int c = 0; c < CH; c++)
            if (latch2_r[c])
                level_nxt[c*LW +: LW] = alt_s ? scd_pkg::LVL_SEL_NEG : scd_pkg::LVL_SEL_POS;
            else
                level_nxt[c*LW +: LW] = alt_s ? scd_pkg::LVL_NON_NEG : scd_pkg::LVL_NON_POS;
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            latch1_r <= '0;
            latch2_r <= '0;
            level_r <= '0;
            lo_oe_n_r <= 1'b1;
            ro_oe_n_r <= 1'b1;
            lo_r <= 1'b0;
            ro_r <= 1'b0;
        end
        else
        begin
            latch1_r <= latch1_nxt;
            latch2_r <= latch2_nxt;
            level_r <= level_nxt;
            lo_oe_n_r <= ~dir_s;
            ro_oe_n_r <= dir_s;
            lo_r <= dout_nxt;
            ro_r <= dout_nxt;
        end
    end

    assign left_serial_port_o = lo_r;
    assign left_serial_port_oe_n = lo_oe_n_r;
    assign right_serial_port_o = ro_r;
    assign right_serial_port_oe_n = ro_oe_n_r;
    assign chain_carry_n = carry_n_r;
    assign drive_level = level_r;

    // Checks
    sequence s_last_bit;
        done_evt && !l1_rise && !l1_s;
    endsequence
    sequence s_line_end;
        !chain_carry_n && !en_flag_r && cnt_r == scd_pkg::CNT_ZERO;
    endsequence

    a_line_done_carry: assert property (@(posedge core_clk) disable iff (!rstn) s_last_bit |=> s_line_end)
        else $error("carry or flag wrong after last bit");
    a_carry_release_rise: assert property (@(posedge core_clk) disable iff (!rstn) l1_rise |=> chain_carry_n)
        else $error("carry not released on latch rise");
    a_latch2_line_copy: assert property (@(posedge core_clk) disable iff (!rstn)
        l1_fall |=> latch2_r == $past(latch1_r))
        else $error("second latch missed line copy");
    a_strobe_one_hot: assert property (@(posedge core_clk) disable iff (!rstn) $onehot0(strobe))
        else $error("more than one group strobe");
    a_idle_latch_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        (!pop_if.valid && !active) |=> latch1_r == $past(latch1_r))
        else $error("first latch changed while idle");
    a_level_map_ch0: assert property (@(posedge core_clk) disable iff (!rstn)
        1'b1 |=> drive_level[LW-1:0] == {~$past(latch2_r[0]), $past(alt_s)})
        else $error("channel one level wrong");
    a_dir_low_ports: assert property (@(posedge core_clk) disable iff (!rstn)
        !dir_s |=> !right_serial_port_oe_n && left_serial_port_oe_n)
        else $error("port enables wrong for direction low");
    a_dir_high_ports: assert property (@(posedge core_clk) disable iff (!rstn)
        dir_s |=> right_serial_port_oe_n && !left_serial_port_oe_n)
        else $error("port enables wrong for direction high");
    a_flag_set_high: assert property (@(posedge core_clk) disable iff (!rstn) l1_s |=> en_flag_r)
        else $error("enable flag not set while latch clock high");
    a_group_push_due: assert property (@(posedge core_clk) disable iff (!rstn)
        (take && cnt_r[GL-1:0] == scd_pkg::NIB_LAST && !l1_rise) |=> push_if.valid)
        else $error("completed group not offered");
endmodule : scd_top

// File: dv/scd_ctrl_model.sv
// Behavioural display controller that feeds clocks and serial data to the driver
`timescale 1ns/100ps
module scd_ctrl_model (
    // Clock for pacing
    input wire logic core_clk,
    // Direction set by the bench
    input wire logic shift_direction_select,
    // Controller outputs
    output logic line_latch_clock,
    output logic serial_shift_clock,
    output logic left_d,
    output logic right_d
);
    logic data_r;

    // Port left to the device carries the inverse, never a stale copy
    assign left_d = shift_direction_select ? ~data_r : data_r;
    assign right_d = shift_direction_select ? data_r : ~data_r;

    initial
    begin
        line_latch_clock = 1'b0;
        serial_shift_clock = 1'b0;
        data_r = 1'b0;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    // High phase arms the enable flag, the fall copies the line
    task automatic pulse_latch();
        line_latch_clock = 1'b1;
        cyc(8);
        line_latch_clock = 1'b0;
        cyc(8);
    endtask : pulse_latch

    // Shift clock runs only inside a burst; bits per latch pulse set the duty
    task automatic send_bits(input logic [79:0] bits, input int n);
        for (int k = 0; k < n; k++)
        begin
            data_r = bits[k % 80];
            serial_shift_clock = 1'b1;
            cyc(4);
            serial_shift_clock = 1'b0;
            cyc(4);
        end
        data_r = ~data_r;
        cyc(8);
    endtask : send_bits
endmodule : scd_ctrl_model

// File: dv/scd_top_tb.sv
// Self-checking bench for the serial column driver core
`timescale 1ns/100ps
module scd_top_tb;
    logic core_clk, rstn, dir, alt, chain_enable_n;
    logic line_latch_clock, serial_shift_clock, left_d, right_d;
    logic left_o, left_oe_n, right_o, right_oe_n, carry_n, left_pin, right_pin;
    logic [scd_pkg::CHANNELS*scd_pkg::LVL_W-1:0] drive_level;
    int err_count;
    int check_count;

    // Pin level seen by both parties
    assign left_pin = left_oe_n ? left_d : left_o;
    assign right_pin = right_oe_n ? right_d : right_o;

    scd_ctrl_model u_scd_ctrl_model (.core_clk(core_clk), .shift_direction_select(dir),
        .line_latch_clock(line_latch_clock), .serial_shift_clock(serial_shift_clock),
        .left_d(left_d), .right_d(right_d));

    scd_top u_scd_top (.core_clk(core_clk), .rstn(rstn), .line_latch_clock(line_latch_clock),
        .serial_shift_clock(serial_shift_clock), .shift_direction_select(dir), .alternation(alt),
        .chain_enable_n(chain_enable_n), .left_serial_port_i(left_pin), .left_serial_port_o(left_o),
        .left_serial_port_oe_n(left_oe_n), .right_serial_port_i(right_pin),
        .right_serial_port_o(right_o), .right_serial_port_oe_n(right_oe_n),
        .chain_carry_n(carry_n), .drive_level(drive_level));

    always #20 core_clk = ~core_clk;

    task automatic cmp_bit(input string name, input logic exp, input logic got);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_bit

    task automatic cmp_line(input string name, input logic [159:0] exp, input logic [159:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_line

    function automatic logic [159:0] exp_drive(input logic [79:0] bits, input logic d, input logic a);
        logic b;
        exp_drive = '0;
        for (int c = 0; c < 80; c++)
        begin
            b = d ? bits[79-c] : bits[c];
            exp_drive[2*c +: 2] = b ? (a ? scd_pkg::LVL_SEL_NEG : scd_pkg::LVL_SEL_POS)
                                    : (a ? scd_pkg::LVL_NON_NEG : scd_pkg::LVL_NON_POS);
        end
    endfunction : exp_drive

    // Full line, extra bits after the last one, copy, then both polarities
    task automatic t_line(input logic [79:0] p, input logic d);
        dir = d;
        alt = 1'b0;
        chain_enable_n = 1'b0;
        u_scd_ctrl_model.cyc(8);
        u_scd_ctrl_model.pulse_latch();
        u_scd_ctrl_model.send_bits(p, 80);
        cmp_bit("carry_after_line", 1'b0, carry_n);
        cmp_bit("right_oe_n", d, right_oe_n);
        cmp_bit("left_oe_n", ~d, left_oe_n);
        u_scd_ctrl_model.send_bits(~p, 4);
        cmp_bit("left_o", p[79], left_o);
        cmp_bit("right_o", p[79], right_o);
        u_scd_ctrl_model.pulse_latch();
        cmp_bit("carry_released", 1'b1, carry_n);
        cmp_line("drive_alt0", exp_drive(p, d, 1'b0), drive_level);
        alt = 1'b1;
        u_scd_ctrl_model.cyc(8);
        cmp_line("drive_alt1", exp_drive(p, d, 1'b1), drive_level);
    endtask : t_line

    // Chain enable held off: no bit taken, copy repeats the old line
    task automatic t_idle(input logic [79:0] prev);
        chain_enable_n = 1'b1;
        u_scd_ctrl_model.pulse_latch();
        u_scd_ctrl_model.send_bits(~prev, 80);
        cmp_bit("carry_idle", 1'b1, carry_n);
        u_scd_ctrl_model.pulse_latch();
        cmp_line("drive_held", exp_drive(prev, dir, alt), drive_level);
    endtask : t_idle

    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    initial
    begin
        core_clk = 1'b0;
        rstn = 1'b0;
        dir = 1'b0;
        alt = 1'b0;
        chain_enable_n = 1'b1;
        err_count = 0;
        check_count = 0;
        repeat (4) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        cmp_line("drive_reset", '0, drive_level);
        cmp_bit("carry_reset", 1'b1, carry_n);
        t_line(80'h8000_f0a5_1234_5678_9ac1, 1'b0);
        t_line(80'h0001_3c96_fedc_ba98_7653, 1'b1);
        t_idle(80'h0001_3c96_fedc_ba98_7653);
        close_out();
    end

    // Watchdog well beyond the roughly 2200 cycles of traffic
    initial
    begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        close_out();
    end
endmodule : scd_top_tb
